// File: src/ulrm_mapper.sv
// Uplink resource grid mapper with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module ulrm_mapper #(
   parameter int N_RBG_P = ulrm_pkg::N_RBG
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        re_ready,
   output logic             re_valid,
   output logic      [2:0]  re_class,
   output logic      [3:0]  re_sf,
   output logic      [3:0]  re_sym,
   output logic      [10:0] re_sc,
   output logic      [10:0] re_seq_idx,
   output logic      [10:0] re_zc_idx,
   output logic      [2:0]  re_qm
);
   initial begin
      if (N_RBG_P != ulrm_pkg::N_RBG) begin
         $error("N_RBG_P must equal the fixed grid of 25 groups");
      end
   end

   // ==================================================
   // Functions
   function automatic logic alloc_contig(input logic [24:0] m);
      logic [24:0] low;
      low = m & (~m + 25'h000_0001);
      return (m != 25'h000_0000) && (((m + low) & m) == 25'h000_0000);
   endfunction

   function automatic logic [6:0] alloc_prbs(input logic [24:0] m);
      logic [6:0] n;
      n = 7'h00;
      for (int i = 0; i < ulrm_pkg::N_RBG; i++) begin
         n = n + {6'h00, m[i]};
      end
      return 7'(n * 7'(ulrm_pkg::PRB_PER_RBG));
   endfunction

   function automatic logic [10:0] wrap_inc(input logic [10:0] v, input logic [10:0] len);
      return (v == len - 11'h001) ? 11'h000 : v + 11'h001;
   endfunction

   // ==================================================
   // Registers
   logic [4:0]  ctrl_q;
   logic [24:0] alloc_q;
   logic [4:0]  mcs_q;
   logic [9:0]  sched_q;
   logic [9:0]  ul_pat_q;
   logic [9:0]  sp_pat_q;
   logic        mcs_err_q;
   logic        alloc_ok;
   logic [6:0]  n_prb;
   logic [2:0]  qm;
   logic        run, srs_en, tdd, comb, rx_side;

   assign run     = ctrl_q[ulrm_pkg::CTRL_RUN];
   assign srs_en  = ctrl_q[ulrm_pkg::CTRL_SRS_EN];
   assign tdd     = ctrl_q[ulrm_pkg::CTRL_TDD];
   assign comb    = ctrl_q[ulrm_pkg::CTRL_COMB];
   assign rx_side = ctrl_q[ulrm_pkg::CTRL_RX];
   assign alloc_ok = alloc_contig(alloc_q);
   assign n_prb    = alloc_ok ? alloc_prbs(alloc_q) : 7'h00;

   always_comb begin
      if (mcs_q >= ulrm_pkg::MCS_QM6) begin
         qm = ulrm_pkg::QM_6;
      end else if (mcs_q >= ulrm_pkg::MCS_QM4) begin
         qm = ulrm_pkg::QM_4;
      end else begin
         qm = ulrm_pkg::QM_2;
      end
   end

   // ==================================================
   // AHB-Lite slave: writes zero-wait, reads one wait state
   logic        acc;
   logic        wr_pend_q;
   logic        rd_pend_q;
   logic [7:0]  addr_q;
   logic [31:0] rd_mux;
   logic [31:0] status;

   assign acc = hsel && hready && (htrans == ulrm_pkg::HTRANS_NONSEQ ||
                                   htrans == ulrm_pkg::HTRANS_SEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
      end else begin
         if (hready) begin
            wr_pend_q <= acc && hwrite;
            rd_pend_q <= acc && !hwrite;
            if (acc) begin
               addr_q <= haddr[7:0];
            end
         end else begin
            rd_pend_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         if (acc && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend_q) begin
            hreadyout <= 1'b1;
            hrdata    <= rd_mux;
         end
      end
   end

   assign status = {9'h000, n_prb, 3'h0, qm, mcs_err_q, !alloc_ok,
                    re_sym, re_sf};

   always_comb begin
      case (addr_q)
         ulrm_pkg::OFF_CTRL:   rd_mux = {27'h000_0000, ctrl_q};
         ulrm_pkg::OFF_ALLOC:  rd_mux = {7'h00, alloc_q};
         ulrm_pkg::OFF_MCS:    rd_mux = {27'h000_0000, mcs_q};
         ulrm_pkg::OFF_SCHED:  rd_mux = {22'h00_0000, sched_q};
         ulrm_pkg::OFF_TDDPAT: rd_mux = {6'h00, sp_pat_q, 6'h00, ul_pat_q};
         ulrm_pkg::OFF_STATUS: rd_mux = status;
         default:              rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q   <= ulrm_pkg::RST_CTRL[4:0];
         alloc_q  <= ulrm_pkg::RST_ALLOC;
         mcs_q    <= ulrm_pkg::RST_MCS;
         sched_q  <= ulrm_pkg::RST_SCHED;
         ul_pat_q <= ulrm_pkg::RST_UL_PAT;
         sp_pat_q <= ulrm_pkg::RST_SP_PAT;
      end else if (wr_pend_q) begin
         case (addr_q)
            ulrm_pkg::OFF_CTRL:   ctrl_q  <= hwdata[4:0];
            ulrm_pkg::OFF_ALLOC:  alloc_q <= hwdata[24:0];
            ulrm_pkg::OFF_MCS: begin
               if (hwdata[4:0] <= ulrm_pkg::MCS_MAX) begin
                  mcs_q <= hwdata[4:0];
               end
            end
            ulrm_pkg::OFF_SCHED:  sched_q <= hwdata[9:0];
            ulrm_pkg::OFF_TDDPAT: begin
               ul_pat_q <= hwdata[ulrm_pkg::PAT_UL_LSB +: 10];
               sp_pat_q <= hwdata[ulrm_pkg::PAT_SP_LSB +: 10];
            end
            default: ;
         endcase
      end
   end

   // Sticky refusal flag, cleared by writing one; a new refusal wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mcs_err_q <= 1'b0;
      end else if (wr_pend_q && addr_q == ulrm_pkg::OFF_MCS &&
                   hwdata[4:0] > ulrm_pkg::MCS_MAX) begin
         mcs_err_q <= 1'b1;
      end else if (wr_pend_q && addr_q == ulrm_pkg::OFF_STATUS &&
                   hwdata[ulrm_pkg::ST_MCS_ERR]) begin
         mcs_err_q <= 1'b0;
      end
   end

   // ==================================================
   // Grid walker: subframe, symbol, subcarrier slot
   logic [3:0]  sf_q, sym_q;
   logic [10:0] slot_q;
   logic [6:0]  prb_q;
   logic [3:0]  sub_q;
   logic [10:0] dmrs_n_q, dmrs_zc_q, srs_n_q, srs_zc_q;
   logic        adv, is_dc, sym_end;
   logic [10:0] k;

   assign adv     = run && (!re_valid || re_ready);
   assign is_dc   = (slot_q == ulrm_pkg::DC_SLOT);
   assign k       = (slot_q > ulrm_pkg::DC_SLOT) ? slot_q - 11'h001 : slot_q;
   assign sym_end = (slot_q == ulrm_pkg::LAST_SLOT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sf_q   <= 4'h0;
         sym_q  <= 4'h1;
         slot_q <= 11'h000;
         prb_q  <= 7'h00;
         sub_q  <= 4'h0;
      end else if (adv) begin
         if (sym_end) begin
            slot_q <= 11'h000;
            prb_q  <= 7'h00;
            sub_q  <= 4'h0;
            if (sym_q == 4'(ulrm_pkg::N_SYM)) begin
               sym_q <= 4'h1;
               sf_q  <= (sf_q == 4'(ulrm_pkg::N_SF - 1)) ? 4'h0 : sf_q + 4'h1;
            end else begin
               sym_q <= sym_q + 4'h1;
            end
         end else begin
            slot_q <= slot_q + 11'h001;
            if (!is_dc) begin
               if (sub_q == 4'(ulrm_pkg::SC_PER_PRB - 1)) begin
                  sub_q <= 4'h0;
                  prb_q <= prb_q + 7'h01;
               end else begin
                  sub_q <= sub_q + 4'h1;
               end
            end
         end
      end
   end

   // ==================================================
   // Subframe type, sounding schedule and element class
   logic [3:0]  sf_prev;
   logic        sf_ul, sf_sp, prev_dl, rbg_on, in_srs, srs_last, srs_prev;
   logic [2:0]  cls;

   assign sf_prev  = (sf_q == 4'h0) ? 4'(ulrm_pkg::N_SF - 1) : sf_q - 4'h1;
   assign sf_ul    = !tdd || ul_pat_q[sf_q];
   assign sf_sp    = tdd && sp_pat_q[sf_q] && !ul_pat_q[sf_q];
   assign prev_dl  = tdd && !ul_pat_q[sf_prev] && !sp_pat_q[sf_prev];
   assign rbg_on   = alloc_ok && (prb_q < 7'(ulrm_pkg::N_PRB)) &&
                     alloc_q[prb_q[6:2]];
   assign in_srs   = (k >= ulrm_pkg::SRS_K0) && (k < ulrm_pkg::SRS_K_END) &&
                     (k[0] == comb);
   assign srs_last = sched_q[sf_q] && (sf_ul || sf_sp);
   assign srs_prev = sched_q[sf_prev] && prev_dl;

   always_comb begin
      cls = ulrm_pkg::RE_NONE;
      if (is_dc) begin
         cls = ulrm_pkg::RE_DC;
      end else if (sf_ul) begin
         if (srs_en && sym_q == ulrm_pkg::SYM_LAST) begin
            cls = (srs_last && in_srs) ? ulrm_pkg::RE_SRS : ulrm_pkg::RE_RSV;
         end else if (sym_q == ulrm_pkg::DMRS_SYM_A ||
                      sym_q == ulrm_pkg::DMRS_SYM_B) begin
            cls = rbg_on ? ulrm_pkg::RE_DMRS : ulrm_pkg::RE_NONE;
         end else begin
            // Data only, single port, no transform spreading
            cls = rbg_on ? ulrm_pkg::RE_PUSCH : ulrm_pkg::RE_NONE;
         end
      end else if (sf_sp && srs_en) begin
         if (sym_q == ulrm_pkg::SYM_LAST) begin
            cls = (srs_last && in_srs) ? ulrm_pkg::RE_SRS : ulrm_pkg::RE_RSV;
         end else if (sym_q == ulrm_pkg::SYM_PREV) begin
            cls = (srs_prev && in_srs) ? ulrm_pkg::RE_SRS : ulrm_pkg::RE_RSV;
         end
      end
   end

   // Sequence indices restart every symbol; fixed root, no hopping
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dmrs_n_q  <= 11'h000;
         dmrs_zc_q <= 11'h000;
         srs_n_q   <= 11'h000;
         srs_zc_q  <= 11'h000;
      end else if (adv) begin
         if (sym_end) begin
            dmrs_n_q  <= 11'h000;
            dmrs_zc_q <= 11'h000;
            srs_n_q   <= 11'h000;
            srs_zc_q  <= 11'h000;
         end else if (cls == ulrm_pkg::RE_DMRS) begin
            dmrs_n_q  <= wrap_inc(dmrs_n_q, ulrm_pkg::DMRS_LEN);
            dmrs_zc_q <= wrap_inc(dmrs_zc_q, ulrm_pkg::DMRS_ZC_LEN);
         end else if (cls == ulrm_pkg::RE_SRS) begin
            srs_n_q   <= wrap_inc(srs_n_q, ulrm_pkg::SRS_LEN);
            srs_zc_q  <= wrap_inc(srs_zc_q, ulrm_pkg::SRS_ZC_LEN);
         end
      end
   end

   // ==================================================
   // Output stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         re_valid   <= 1'b0;
         re_class   <= ulrm_pkg::RE_NONE;
         re_sf      <= 4'h0;
         re_sym     <= 4'h0;
         re_sc      <= 11'h000;
         re_seq_idx <= 11'h000;
         re_zc_idx  <= 11'h000;
         re_qm      <= ulrm_pkg::QM_2;
      end else if (adv) begin
         re_valid <= 1'b1;
         re_class <= cls;
         re_sf    <= sf_q;
         re_sym   <= sym_q;
         re_sc    <= k;
         re_qm    <= qm;
         if (cls == ulrm_pkg::RE_DMRS) begin
            re_seq_idx <= dmrs_n_q;
            re_zc_idx  <= dmrs_zc_q;
         end else if (cls == ulrm_pkg::RE_SRS && !rx_side) begin
            re_seq_idx <= srs_n_q;
            re_zc_idx  <= srs_zc_q;
         end else begin
            // Receiver takes sounding elements without sequence work
            re_seq_idx <= 11'h000;
            re_zc_idx  <= 11'h000;
         end
      end else if (re_ready) begin
         re_valid <= 1'b0;
      end
   end

   // ==================================================
   // Assertions
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_dc_empty;
      re_valid && re_sc == 11'h258 && $past(slot_q) == 11'h258 |-> re_class == 3'b101;
   endproperty
   a_dc_empty: assert property (p_dc_empty) else $error("DC slot not empty");

   property p_dmrs_sym;
      re_valid && re_class == 3'b010 |-> re_sym == 4'h4 || re_sym == 4'hb;
   endproperty
   a_dmrs_sym: assert property (p_dmrs_sym) else $error("DMRS off symbol");

   property p_srs_sym;
      re_valid && re_class == 3'b011 |-> re_sym == 4'he || re_sym == 4'hd;
   endproperty
   a_srs_sym: assert property (p_srs_sym) else $error("Sounding off symbol");

   property p_last_free;
      re_valid && re_sym == 4'he && $past(srs_en) && srs_en |-> re_class != 3'b001;
   endproperty
   a_last_free: assert property (p_last_free) else $error("Data in sounding symbol");

   property p_mcs_range;
      adv |=> mcs_q <= 5'h1c &&
              re_qm == (($past(mcs_q) >= 5'h11) ? 3'h6 :
                        ($past(mcs_q) >= 5'h0a) ? 3'h4 : 3'h2);
   endproperty
   a_mcs_range: assert property (p_mcs_range) else $error("Coding index out of range");

   property p_comb;
      re_valid && re_class == 3'b011 |-> re_sc[0] == $past(comb) &&
                                        re_sc >= 11'h018 && re_sc < 11'h498;
   endproperty
   a_comb: assert property (p_comb) else $error("Sounding comb or band wrong");

   property p_seq_trunc;
      re_valid && re_class == 3'b010 |-> re_seq_idx < 11'h4b0 && re_zc_idx < 11'h4a9;
   endproperty
   a_seq_trunc: assert property (p_seq_trunc) else $error("DMRS index overrun");

   property p_contig;
      re_valid && re_class == 3'b001 |-> $past(alloc_ok);
   endproperty
   a_contig: assert property (p_contig) else $error("Data on split allocation");

   property p_hold;
      re_valid && !re_ready |=> re_valid && $stable(re_class) && $stable(re_sc);
   endproperty
   a_hold: assert property (p_hold) else $error("Element dropped under stall");

   property p_read_wait;
      acc && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_read_wait: assert property (p_read_wait) else $error("Read wait state wrong");
endmodule
`default_nettype wire

// File: src/ulrm_pkg.sv
// Package with constants for the uplink resource mapper
package ulrm_pkg;
   // ==================================================
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_ALLOC   = 8'h04;
   localparam logic [7:0] OFF_MCS     = 8'h08;
   localparam logic [7:0] OFF_SCHED   = 8'h0c;
   localparam logic [7:0] OFF_TDDPAT  = 8'h10;
   localparam logic [7:0] OFF_STATUS  = 8'h14;
   // ==================================================
   // Field positions
   localparam int CTRL_RUN     = 0;
   localparam int CTRL_SRS_EN  = 1;
   localparam int CTRL_TDD     = 2;
   localparam int CTRL_COMB    = 3;
   localparam int CTRL_RX      = 4;
   localparam int PAT_UL_LSB   = 0;
   localparam int PAT_SP_LSB   = 16;
   localparam int ST_ALLOC_ERR = 8;
   localparam int ST_MCS_ERR   = 9;
   // ==================================================
   // Reset values
   localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
   localparam logic [24:0] RST_ALLOC  = 25'h000_0000;
   localparam logic [4:0]  RST_MCS    = 5'h00;
   localparam logic [9:0]  RST_SCHED  = 10'h000;
   localparam logic [9:0]  RST_UL_PAT = 10'h000;
   localparam logic [9:0]  RST_SP_PAT = 10'h000;
   // ==================================================
   // Grid geometry and sequence figures
   localparam int          N_RBG       = 25;
   localparam int          PRB_PER_RBG = 4;
   localparam int          SC_PER_PRB  = 12;
   localparam int          N_PRB       = 100;
   localparam int          N_SYM       = 14;
   localparam int          N_SF        = 10;
   localparam logic [10:0] DC_SLOT     = 11'h258;   // 600
   localparam logic [10:0] LAST_SLOT   = 11'h4b0;   // 1200
   localparam logic [3:0]  DMRS_SYM_A  = 4'h4;
   localparam logic [3:0]  DMRS_SYM_B  = 4'hb;
   localparam logic [3:0]  SYM_LAST    = 4'he;
   localparam logic [3:0]  SYM_PREV    = 4'hd;
   localparam logic [10:0] DMRS_ZC_LEN = 11'h4a9;   // 1193
   localparam logic [10:0] DMRS_LEN    = 11'h4b0;   // 1200
   localparam logic [10:0] SRS_ZC_LEN  = 11'h23b;   // 571
   localparam logic [10:0] SRS_LEN     = 11'h240;   // 576
   localparam logic [10:0] SRS_K0      = 11'h018;   // 24, band start
   localparam logic [10:0] SRS_K_END   = 11'h498;   // 24 + 96*12
   localparam logic [4:0]  MCS_MAX     = 5'h1c;     // 28
   localparam logic [4:0]  MCS_QM4     = 5'h0a;
   localparam logic [4:0]  MCS_QM6     = 5'h11;
   localparam logic [2:0]  QM_2        = 3'h2;
   localparam logic [2:0]  QM_4        = 3'h4;
   localparam logic [2:0]  QM_6        = 3'h6;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
   // ==================================================
   // Resource element classes
   typedef enum logic [2:0] {
      RE_NONE  = 3'b000,
      RE_PUSCH = 3'b001,
      RE_DMRS  = 3'b010,
      RE_SRS   = 3'b011,
      RE_RSV   = 3'b100,
      RE_DC    = 3'b101
   } ulrm_class_e;
endpackage

// File: bench/ulrm_sink.sv
// Downstream consumer of the element stream, stalling at random
`timescale 1ns/1ps
`default_nettype none
module ulrm_sink (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic re_valid,
   output logic      re_ready
);
   // Refuses about one cycle in eight so held elements are exercised
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         re_ready <= 1'b0;
      end else if (re_valid) begin
         re_ready <= ($urandom % 8) != 0;
      end
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench for the uplink resource mapper
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        re_ready;
   logic        re_valid;
   logic [2:0]  re_class;
   logic [2:0]  re_qm;
   logic [3:0]  re_sf;
   logic [3:0]  re_sym;
   logic [10:0] re_sc;
   logic [10:0] re_seq_idx;
   logic [10:0] re_zc_idx;
   logic [31:0] rd;
   int          bad_count = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          ctl, lo, hi, mcs, sched, ul, sp;
   int          msf, msym, mslot;
   int          mleft = 0;
   int          mv[8] = '{0, 9, 10, 16, 17, 28, 29, 31};

   always #5 hclk = ~hclk;

   ulrm_mapper i_ulrm_mapper (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .re_ready(re_ready),
      .re_valid(re_valid), .re_class(re_class), .re_sf(re_sf), .re_sym(re_sym), .re_sc(re_sc),
      .re_seq_idx(re_seq_idx), .re_zc_idx(re_zc_idx), .re_qm(re_qm));
   ulrm_sink i_ulrm_sink (.hclk(hclk), .hresetn(hresetn), .re_valid(re_valid),
      .re_ready(re_ready));

   // ==================================================
   // Comparison, bus and verdict
   task check(input logic [46:0] seen, input logic [46:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task results;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= ulrm_pkg::HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check({14'h0, hresp, rd}, {15'h0, exp});
   endtask

   function automatic logic [2:0] qm_of(int m);
      if (m < int'(ulrm_pkg::MCS_QM4)) return ulrm_pkg::QM_2;
      if (m < int'(ulrm_pkg::MCS_QM6)) return ulrm_pkg::QM_4;
      return ulrm_pkg::QM_6;
   endfunction

   // ==================================================
   // Reference grid model
   function automatic logic [46:0] expect_el(int sf, int sym, int slot);
      int sc, grp, cls, seq, zc, msk, pv;
      bit isul, issp, band, on;
      sc = (slot > 600) ? slot - 1 : slot;
      grp = sc / 48;
      isul = !ctl[2] || ul[sf];
      issp = ctl[2] && sp[sf];
      band = sc >= 24 && sc < 1176 && (sc % 2) == ctl[3];
      msk = ctl[2] ? (sched & (ul | sp)) : sched;
      pv = (sf + 9) % 10;
      cls = 0;
      seq = 0;
      if (slot == 600) begin
         cls = 5;
      end else if (isul) begin
         if (ctl[1] && sym == 14) begin
            cls = (msk[sf] && band) ? 3 : 4;
         end else if (grp >= lo && grp <= hi) begin
            cls = (sym == 4 || sym == 11) ? 2 : 1;
         end
      end else if (issp && ctl[1] && sym >= 13) begin
         on = (sym == 14) ? msk[sf] : (sched[pv] && !ul[pv] && !sp[pv]);
         cls = (on && band) ? 3 : 4;
      end
      if (cls == 2) seq = sc - lo * 48;
      if (cls == 3) seq = (sc - 24) / 2;
      if (cls == 3 && ctl[4]) seq = 0;
      zc = (cls == 2) ? seq % 1193 : (cls == 3) ? seq % 571 : 0;
      return {sf[3:0], sym[3:0], sc[10:0], cls[2:0], seq[10:0], zc[10:0], qm_of(mcs)};
   endfunction

   always @(posedge hclk) begin
      if (mleft > 0 && re_valid === 1'b1 && re_ready === 1'b1) begin
         check({re_sf, re_sym, re_sc, re_class, re_seq_idx, re_zc_idx, re_qm},
               expect_el(msf, msym, mslot));
         mleft--;
         mslot++;
         if (mslot == 1201) begin
            mslot = 0;
            msym++;
         end
         if (msym == 15) begin
            msym = 1;
            msf++;
         end
      end
      cyc++;
      if (cyc == 80000) begin
         bad_count++;
         results();
      end
   end

   // ==================================================
   // Stimulus
   task config_all;
      bus(1'b1, ulrm_pkg::OFF_ALLOC, ((32'h1 << (hi + 1)) - 1) ^ ((32'h1 << lo) - 1));
      bus(1'b1, ulrm_pkg::OFF_MCS, mcs);
      bus(1'b1, ulrm_pkg::OFF_SCHED, sched);
      bus(1'b1, ulrm_pkg::OFF_TDDPAT, (sp << 16) | ul);
      bus(1'b1, ulrm_pkg::OFF_CTRL, ctl);
   endtask

   task run_sf(input int n);
      msf = 0;
      msym = 1;
      mslot = 0;
      mleft = n * 16814;
      bus(1'b1, ulrm_pkg::OFF_CTRL, ctl | 1);
      while (mleft > 0) @(posedge hclk);
      bus(1'b1, ulrm_pkg::OFF_CTRL, ctl);
   endtask

   initial begin
      void'($urandom(44858));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rchk(ulrm_pkg::OFF_CTRL, ulrm_pkg::RST_CTRL);
      rchk(ulrm_pkg::OFF_ALLOC, 32'(ulrm_pkg::RST_ALLOC));
      rchk(ulrm_pkg::OFF_SCHED, 32'(ulrm_pkg::RST_SCHED));
      rchk(ulrm_pkg::OFF_STATUS, 32'h0000_0900);
      bus(1'b1, 8'h18, 32'hffff_ffff);
      rchk(8'h18, 32'h0);
      $display("test reset done");
      foreach (mv[i]) begin
         if (mv[i] <= 28) mcs = mv[i];
         bus(1'b1, ulrm_pkg::OFF_MCS, mv[i]);
         rchk(ulrm_pkg::OFF_MCS, mcs);
         bus(1'b0, ulrm_pkg::OFF_STATUS, 32'h0);
         check({43'h0, rd[12:9]}, {43'h0, qm_of(mcs), mv[i] > 28});
         bus(1'b1, ulrm_pkg::OFF_STATUS, 32'h200);
      end
      $display("test coding index done");
      bus(1'b1, ulrm_pkg::OFF_ALLOC, 32'h5);
      bus(1'b0, ulrm_pkg::OFF_STATUS, 32'h0);
      check({46'h0, rd[8]}, 47'h1);
      lo = $urandom % 25;
      hi = lo + $urandom % (25 - lo);
      mcs = $urandom % 29;
      sched = $urandom % 1024;
      ctl = 32'h2 | (($urandom % 2) << 3);
      ul = 0;
      sp = 0;
      config_all();
      bus(1'b0, ulrm_pkg::OFF_STATUS, 32'h0);
      check({39'h0, rd[22:16], rd[8]}, {39'h0, 7'((hi - lo + 1) * 4), 1'b0});
      $display("test allocation done");
      run_sf(1);
      $display("test fdd stream done");
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ul = 10'h39c;
      sp = 10'h042;
      sched = ($urandom % 1024) | 3;
      ctl = (ctl ^ 32'hc) | 32'h10;
      config_all();
      run_sf(2);
      $display("test tdd stream done");
      results();
   end
endmodule
`default_nettype wire
